// file: tcc_top.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`include "tcc_defs.svh"

// What this block does
// - A channel captures from its input pin when the source bit is 0 and from the masked radio events when it is 1.
// - Each channel has an interrupt mask bit, set after reset, that enables its interrupt request.
// - In compare mode a counter match sets, clears or toggles the output for actions 000, 001 and 010.
// - Action 011 sets on an up match and clears at zero, or on the down match when counting up and down.
// - Action 100 clears on an up match and sets at zero, or on the down match when counting up and down.
// - Action 101 sets on a match with the channel value and clears on a match with the channel 0 value.
// - Action 110 clears on a match with the channel value and sets on a match with the channel 0 value.
// - Action 111 on channel 1 runs delta-sigma output at one eighth or one quarter of the tick by the mode bit.
// - Outside delta-sigma the mode bit picks capture when 0 and compare when 1.
// - The edge field disables capture or captures on rising, falling or both edges.
// - In delta-sigma the edge field turns the interpolator and the output shaping on or off.
// - The channel 0 value is sixteen bits in two bytes reset to zero and sets the delta-sigma sample rate.
// - In delta-sigma the channel 1 value is the data word and its two lowest bits are ignored.
// - The compare action fires when the counter equals the channel's own value.
// - The counter wraps at the channel 0 value in modulo mode and turns back down to zero in up/down mode.

module tcc_top #(
	parameter int CNT_W = 16,
	parameter int RADIO_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// pins
	input wire logic [1:0] cap_in,
	output logic [1:0] cmp_out,
	// radio events
	input wire logic [RADIO_W-1:0] radio_events,
	// interrupt
	output logic irq
);

	// ****************************************
	// elaboration checks
	// ****************************************
	generate
		if (CNT_W != 16) begin : g_bad_width
			$error("tcc_top serves a 16-bit counter only");
		end
		if (RADIO_W < 1 || RADIO_W > 8) begin : g_bad_radio
			$error("tcc_top radio event width must be 1 to 8");
		end
	endgenerate

	// ****************************************
	// declarations
	// ****************************************
	tcc_pkg::tcc_byte_t val_lo_ff [3];
	tcc_pkg::tcc_byte_t val_hi_ff [3];
	tcc_pkg::tcc_byte_t ctl_ff [1:2];
	tcc_pkg::tcc_cnt_mode_e cnt_mode_ff;
	logic [RADIO_W-1:0] radio_mask_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_mask_ff;
	logic [2:0] irq_set;
	logic [7:0] rdata_ff;
	logic [CNT_W-1:0] count_ff;
	logic down_ff;
	logic ovf_evt;
	logic radio_trig;
	logic [CNT_W-1:0] ch0_value;
	logic [2:1] cap_evt;
	logic [2:1] cmp_evt;
	logic [2:1] dsm_on;
	logic updown;

	assign ch0_value = {val_hi_ff[0], val_lo_ff[0]};
	assign updown = cnt_mode_ff == tcc_pkg::cnt_updown;
	assign radio_trig = |(radio_events & radio_mask_ff);

	// ****************************************
	// counter
	// ****************************************
	// the channels watch this counter; it moves on every clock, but is held in stop mode and kept at zero in modulo and up/down mode with a zero channel 0 value
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_ff <= '0;
			down_ff <= 1'b0;
		end else begin
			case (cnt_mode_ff)
				tcc_pkg::cnt_free: begin
					count_ff <= count_ff + 1'b1;
					down_ff <= 1'b0;
				end
				tcc_pkg::cnt_modulo: begin
					down_ff <= 1'b0;
					if (count_ff >= ch0_value) begin
						count_ff <= '0;
					end else begin
						count_ff <= count_ff + 1'b1;
					end
				end
				tcc_pkg::cnt_updown: begin
					if (ch0_value == '0) begin
						count_ff <= '0;
						down_ff <= 1'b0;
					end else if (!down_ff) begin
						if (count_ff >= ch0_value) begin
							down_ff <= 1'b1;
							count_ff <= count_ff - 1'b1;
						end else begin
							count_ff <= count_ff + 1'b1;
						end
					end else begin
						if (count_ff == '0) begin
							down_ff <= 1'b0;
							count_ff <= count_ff + 1'b1;
						end else begin
							count_ff <= count_ff - 1'b1;
						end
					end
				end
				default: begin
					count_ff <= count_ff;
					down_ff <= down_ff;
				end
			endcase
		end
	end

	always_comb begin
		case (cnt_mode_ff)
			tcc_pkg::cnt_free: ovf_evt = &count_ff;
			tcc_pkg::cnt_modulo: ovf_evt = count_ff >= ch0_value;
			tcc_pkg::cnt_updown: ovf_evt = down_ff && (count_ff == '0);
			default: ovf_evt = 1'b0;
		endcase
	end

	// ****************************************
	// channels 1 and 2
	// ****************************************
	generate
		for (genvar c = 1; c <= 2; c++) begin : g_ch
			tcc_channel #(
				.HAS_DSM(c == 1),
				.CNT_W(CNT_W)
			) u_ch (
				.clk(clk),
				.rst_n(rst_n),
				.ctl(ctl_ff[c]),
				.own_value({val_hi_ff[c], val_lo_ff[c]}),
				.ch0_value(ch0_value),
				.count(count_ff),
				.updown(updown),
				.count_down(down_ff),
				.cap_pin(cap_in[c-1]),
				.radio_trig(radio_trig),
				.cap_evt(cap_evt[c]),
				.cmp_evt(cmp_evt[c]),
				.dsm_on(dsm_on[c]),
				.out_pin(cmp_out[c-1])
			);
		end
	endgenerate

	// ****************************************
	// value registers
	// ****************************************
	// a capture in the same cycle as a software write keeps the captured count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int k = 0; k < 3; k++) begin
				val_lo_ff[k] <= `TCC_VAL_RST;
				val_hi_ff[k] <= `TCC_VAL_RST;
			end
		end else begin
			for (int k = 1; k < 3; k++) begin
				if (cap_evt[k]) begin
					val_lo_ff[k] <= count_ff[7:0];
					val_hi_ff[k] <= count_ff[15:8];
				end
			end
			if (reg_wr) begin
				if (reg_addr == `TCC_ADDR_CH0_LO) begin
					val_lo_ff[0] <= reg_wdata;
				end else if (reg_addr == `TCC_ADDR_CH0_HI) begin
					val_hi_ff[0] <= reg_wdata;
				end else if (reg_addr == `TCC_ADDR_CH1_LO && !cap_evt[1]) begin
					val_lo_ff[1] <= reg_wdata;
				end else if (reg_addr == `TCC_ADDR_CH1_HI && !cap_evt[1]) begin
					val_hi_ff[1] <= reg_wdata;
				end else if (reg_addr == `TCC_ADDR_CH2_LO && !cap_evt[2]) begin
					val_lo_ff[2] <= reg_wdata;
				end else if (reg_addr == `TCC_ADDR_CH2_HI && !cap_evt[2]) begin
					val_hi_ff[2] <= reg_wdata;
				end
			end
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_ff[1] <= `TCC_CTL_RST;
			ctl_ff[2] <= `TCC_CTL_RST;
		end else if (reg_wr) begin
			if (reg_addr == `TCC_ADDR_CTL1) begin
				ctl_ff[1] <= reg_wdata;
			end else if (reg_addr == `TCC_ADDR_CTL2) begin
				ctl_ff[2] <= reg_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_mode_ff <= tcc_pkg::cnt_stop;
			radio_mask_ff <= '0;
		end else if (reg_wr) begin
			if (reg_addr == `TCC_ADDR_CNT_MODE) begin
				cnt_mode_ff <= tcc_pkg::tcc_cnt_mode_e'(reg_wdata[1:0]);
			end else if (reg_addr == `TCC_ADDR_RADIO_MASK) begin
				radio_mask_ff <= reg_wdata[RADIO_W-1:0];
			end
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	// channel events count only while the channel mask bit is set
	assign irq_set[`TCC_IRQ_CH1] = (cap_evt[1] || cmp_evt[1]) && ctl_ff[1][`TCC_CTL_IM];
	assign irq_set[`TCC_IRQ_CH2] = (cap_evt[2] || cmp_evt[2]) && ctl_ff[2][`TCC_CTL_IM];
	assign irq_set[`TCC_IRQ_OVF] = ovf_evt;

	// set beats a write-one clear landing in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_stat_ff <= 3'h0;
		end else if (reg_wr && reg_addr == `TCC_ADDR_IRQ_STAT) begin
			irq_stat_ff <= (irq_stat_ff & ~reg_wdata[2:0]) | irq_set;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_mask_ff <= 3'h0;
		end else if (reg_wr && reg_addr == `TCC_ADDR_IRQ_MASK) begin
			irq_mask_ff <= reg_wdata[2:0];
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	// ****************************************
	// read port
	// ****************************************
	// data stands for one cycle after each cycle of reg_rd, zero otherwise
	always_ff @(posedge clk) begin
		if (!rst_n || !reg_rd) begin
			rdata_ff <= 8'h00;
		end else if (reg_addr == `TCC_ADDR_CH0_LO) begin
			rdata_ff <= val_lo_ff[0];
		end else if (reg_addr == `TCC_ADDR_CH0_HI) begin
			rdata_ff <= val_hi_ff[0];
		end else if (reg_addr == `TCC_ADDR_CH1_LO) begin
			rdata_ff <= val_lo_ff[1];
		end else if (reg_addr == `TCC_ADDR_CH1_HI) begin
			rdata_ff <= val_hi_ff[1];
		end else if (reg_addr == `TCC_ADDR_CH2_LO) begin
			rdata_ff <= val_lo_ff[2];
		end else if (reg_addr == `TCC_ADDR_CH2_HI) begin
			rdata_ff <= val_hi_ff[2];
		end else if (reg_addr == `TCC_ADDR_CTL1) begin
			rdata_ff <= ctl_ff[1];
		end else if (reg_addr == `TCC_ADDR_CTL2) begin
			rdata_ff <= ctl_ff[2];
		end else if (reg_addr == `TCC_ADDR_CNT_MODE) begin
			rdata_ff <= {6'h00, cnt_mode_ff};
		end else if (reg_addr == `TCC_ADDR_RADIO_MASK) begin
			rdata_ff <= 8'(radio_mask_ff);
		end else if (reg_addr == `TCC_ADDR_IRQ_STAT) begin
			rdata_ff <= {5'h00, irq_stat_ff};
		end else if (reg_addr == `TCC_ADDR_IRQ_MASK) begin
			rdata_ff <= {5'h00, irq_mask_ff};
		end else if (reg_addr == `TCC_ADDR_CNT_LO) begin
			rdata_ff <= count_ff[7:0];
		end else if (reg_addr == `TCC_ADDR_CNT_HI) begin
			rdata_ff <= count_ff[15:8];
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign reg_rdata = rdata_ff;

	// ****************************************
	// status view
	// ****************************************
	// delta-sigma state of channel 1 is visible only through its control field
	logic unused_dsm;
	assign unused_dsm = dsm_on[2];

endmodule : tcc_top

// file: tcc_defs.svh
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define TCC_ADDR_CH0_LO 8'hda
`define TCC_ADDR_CH0_HI 8'hdb
`define TCC_ADDR_CH1_LO 8'hdc
`define TCC_ADDR_CH1_HI 8'hdd
`define TCC_ADDR_CH2_LO 8'hde
`define TCC_ADDR_CH2_HI 8'hdf
`define TCC_ADDR_CTL1 8'he6
`define TCC_ADDR_CTL2 8'he7
`define TCC_ADDR_CNT_MODE 8'hf0
`define TCC_ADDR_RADIO_MASK 8'hf1
`define TCC_ADDR_IRQ_STAT 8'hf2
`define TCC_ADDR_IRQ_MASK 8'hf3
`define TCC_ADDR_CNT_LO 8'hf4
`define TCC_ADDR_CNT_HI 8'hf5

// ****************************************
// control fields and reset values
// ****************************************
`define TCC_CTL_SRC 7
`define TCC_CTL_IM 6
`define TCC_CTL_CMP_HI 5
`define TCC_CTL_CMP_LO 3
`define TCC_CTL_MODE 2
`define TCC_CTL_CAP_HI 1
`define TCC_CTL_CAP_LO 0
`define TCC_CTL_RST 8'h40
`define TCC_VAL_RST 8'h00
`define TCC_MASK_RST 8'h00
`define TCC_CMP_SET 3'h0
`define TCC_CMP_CLR 3'h1
`define TCC_CMP_TOG 3'h2
`define TCC_CMP_SET_UP 3'h3
`define TCC_CMP_CLR_UP 3'h4
`define TCC_CMP_SET_OWN 3'h5
`define TCC_CMP_CLR_OWN 3'h6
`define TCC_CMP_DSM 3'h7
`define TCC_CAP_NONE 2'h0
`define TCC_CAP_RISE 2'h1
`define TCC_CAP_FALL 2'h2
`define TCC_CAP_BOTH 2'h3

// ****************************************
// interrupt bits and timing
// ****************************************
`define TCC_IRQ_CH1 0
`define TCC_IRQ_CH2 1
`define TCC_IRQ_OVF 2
`define TCC_DSM_DIV_SLOW 3'h7
`define TCC_DSM_DIV_FAST 3'h3

`endif

// file: tcc_pkg.sv
package tcc_pkg;
	typedef enum logic [1:0] {
		cnt_stop,
		cnt_free,
		cnt_modulo,
		cnt_updown
	} tcc_cnt_mode_e;
	typedef logic [7:0] tcc_byte_t;
endpackage : tcc_pkg

// file: tcc_channel.sv
`timescale 1ns/100ps
`include "tcc_defs.svh"

module tcc_channel #(
	parameter bit HAS_DSM = 1'b0,
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire logic [7:0] ctl,
	input wire logic [CNT_W-1:0] own_value,
	input wire logic [CNT_W-1:0] ch0_value,
	// counter view
	input wire logic [CNT_W-1:0] count,
	input wire logic updown,
	input wire logic count_down,
	// trigger sources
	input wire logic cap_pin,
	input wire logic radio_trig,
	// results
	output logic cap_evt,
	output logic cmp_evt,
	output logic dsm_on,
	output logic out_pin
);
	logic [2:0] act;
	logic [1:0] edge_sel;
	logic sel_in, prev_ff, hit, own_hit, ch0_hit, zero_hit, up_phase;
	logic cap_mode, cmp_mode, nxt_out, dsm_bit, out_ff;

	assign act = ctl[`TCC_CTL_CMP_HI:`TCC_CTL_CMP_LO];
	assign edge_sel = ctl[`TCC_CTL_CAP_HI:`TCC_CTL_CAP_LO];
	assign dsm_on = HAS_DSM && (act == `TCC_CMP_DSM);
	assign cap_mode = !ctl[`TCC_CTL_MODE] && !dsm_on;
	assign cmp_mode = ctl[`TCC_CTL_MODE] && !dsm_on;

	// ****************************************
	// capture
	// ****************************************
	assign sel_in = ctl[`TCC_CTL_SRC] ? radio_trig : cap_pin;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= sel_in;
		end
	end

	always_comb begin
		case (edge_sel)
			`TCC_CAP_RISE: hit = sel_in && !prev_ff;
			`TCC_CAP_FALL: hit = !sel_in && prev_ff;
			`TCC_CAP_BOTH: hit = sel_in != prev_ff;
			default: hit = 1'b0;
		endcase
	end

	assign cap_evt = cap_mode && hit;

	// ****************************************
	// compare
	// ****************************************
	assign own_hit = count == own_value;
	assign ch0_hit = count == ch0_value;
	assign zero_hit = count == '0;
	assign up_phase = !(updown && count_down);
	assign cmp_evt = cmp_mode && own_hit;

	// own match wins when both matches land together
	always_comb begin
		nxt_out = out_ff;
		case (act)
			`TCC_CMP_SET: if (own_hit) nxt_out = 1'b1;
			`TCC_CMP_CLR: if (own_hit) nxt_out = 1'b0;
			`TCC_CMP_TOG: if (own_hit) nxt_out = !out_ff;
			`TCC_CMP_SET_UP: begin
				if (own_hit && up_phase) nxt_out = 1'b1;
				else if (updown ? own_hit : zero_hit) nxt_out = 1'b0;
			end
			`TCC_CMP_CLR_UP: begin
				if (own_hit && up_phase) nxt_out = 1'b0;
				else if (updown ? own_hit : zero_hit) nxt_out = 1'b1;
			end
			`TCC_CMP_SET_OWN: begin
				if (own_hit) nxt_out = 1'b1;
				else if (ch0_hit) nxt_out = 1'b0;
			end
			`TCC_CMP_CLR_OWN: begin
				if (own_hit) nxt_out = 1'b0;
				else if (ch0_hit) nxt_out = 1'b1;
			end
			default: nxt_out = out_ff;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_ff <= 1'b0;
		end else if (dsm_on) begin
			out_ff <= dsm_bit;
		end else if (cmp_mode) begin
			out_ff <= nxt_out;
		end
	end

	assign out_pin = out_ff;

	// ****************************************
	// delta-sigma modulator
	// ****************************************
	generate
		if (HAS_DSM) begin : g_dsm
			logic [2:0] div_ff;
			logic [CNT_W-1:0] rate_ff;
			logic [CNT_W-3:0] cur_ff, prev_smp_ff, drive;
			logic [CNT_W-2:0] avg;
			logic [CNT_W-2:0] sum1, sum2;
			logic [CNT_W-3:0] acc1_ff, acc2_ff;
			logic step, interp_on, shape_on, bit_ff;

			assign step = div_ff == (ctl[`TCC_CTL_MODE] ? `TCC_DSM_DIV_FAST : `TCC_DSM_DIV_SLOW);
			assign interp_on = !edge_sel[1];
			assign shape_on = !edge_sel[0];
			assign avg = {1'b0, cur_ff} + {1'b0, prev_smp_ff};
			// interpolation here is a midpoint between samples, cheap and monotonic
			assign drive = interp_on ? avg[CNT_W-2:1] : cur_ff;
			assign sum1 = {1'b0, acc1_ff} + {1'b0, drive};
			assign sum2 = {1'b0, acc2_ff} + {1'b0, sum1[CNT_W-3:0]};
			assign dsm_bit = bit_ff;

			always_ff @(posedge clk) begin
				if (!rst_n || !dsm_on) begin
					div_ff <= 3'h0;
					rate_ff <= '0;
					cur_ff <= '0;
					prev_smp_ff <= '0;
				end else begin
					div_ff <= step ? 3'h0 : div_ff + 3'h1;
					if (rate_ff >= ch0_value) begin
						rate_ff <= '0;
						prev_smp_ff <= cur_ff;
						cur_ff <= own_value[CNT_W-1:2];
					end else begin
						rate_ff <= rate_ff + 1'b1;
					end
				end
			end

			// shaping adds a second integrator, pushing noise higher in frequency
			always_ff @(posedge clk) begin
				if (!rst_n || !dsm_on) begin
					acc1_ff <= '0;
					acc2_ff <= '0;
					bit_ff <= 1'b0;
				end else if (step) begin
					acc1_ff <= sum1[CNT_W-3:0];
					acc2_ff <= shape_on ? sum2[CNT_W-3:0] : '0;
					bit_ff <= shape_on ? sum2[CNT_W-2] : sum1[CNT_W-2];
				end
			end
		end else begin : g_no_dsm
			assign dsm_bit = 1'b0;
		end
	endgenerate
endmodule : tcc_channel

// file: tcc_properties.sv
`timescale 1ns/100ps
`include "tcc_defs.svh"

module tcc_checker #(
	parameter int CNT_W = 16,
	parameter int RADIO_W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// pins and events
	input wire logic [1:0] cap_in,
	input wire logic [1:0] cmp_out,
	input wire logic [RADIO_W-1:0] radio_events,
	input wire logic irq
);
	// ****
	// shadows of registers the hardware never changes
	// ****
	logic [7:0] c0l_ff, c0h_ff, ct1_ff, ct2_ff, msk_ff;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			c0l_ff <= `TCC_VAL_RST;
			c0h_ff <= `TCC_VAL_RST;
			ct1_ff <= `TCC_CTL_RST;
			ct2_ff <= `TCC_CTL_RST;
			msk_ff <= `TCC_MASK_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				`TCC_ADDR_CH0_LO: c0l_ff <= reg_wdata;
				`TCC_ADDR_CH0_HI: c0h_ff <= reg_wdata;
				`TCC_ADDR_CTL1: ct1_ff <= reg_wdata;
				`TCC_ADDR_CTL2: ct2_ff <= reg_wdata;
				`TCC_ADDR_IRQ_MASK: msk_ff <= reg_wdata;
				default: ;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ****
	// properties
	// ****
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_unmapped;
		reg_rd && reg_addr < `TCC_ADDR_CH0_LO |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_ch0_rb;
		reg_rd && reg_addr[7:1] == 7'h6d |=> reg_rdata == ($past(reg_addr[0]) ? $past(c0h_ff) : $past(c0l_ff));
	endproperty
	a_ch0_rb: assert property (p_ch0_rb) else $error("channel 0 value read back wrong");
	property p_ctl_rb;
		reg_rd && reg_addr[7:1] == 7'h73 |=> reg_rdata == ($past(reg_addr[0]) ? $past(ct2_ff) : $past(ct1_ff));
	endproperty
	a_ctl_rb: assert property (p_ctl_rb) else $error("control read back wrong");
	property p_ch1_hold;
		!ct1_ff[`TCC_CTL_MODE] && ct1_ff[5:3] != `TCC_CMP_DSM |=> $stable(cmp_out[0]);
	endproperty
	a_ch1_hold: assert property (p_ch1_hold) else $error("channel 1 output moved in capture");
	property p_ch2_hold;
		!ct2_ff[`TCC_CTL_MODE] || ct2_ff[5:3] == `TCC_CMP_DSM |=> $stable(cmp_out[1]);
	endproperty
	a_ch2_hold: assert property (p_ch2_hold) else $error("channel 2 output moved");
	property p_irq_off;
		msk_ff[2:0] == 3'h0 |-> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
	property p_rst_quiet;
		$rose(rst_n) |-> cmp_out == 2'h0 && !irq && reg_rdata == 8'h00;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");

	c_out_rise: cover property ($rose(cmp_out[0]));
	c_irq_rise: cover property ($rose(irq));
	c_cap_rise: cover property ($rose(cap_in[0]));
endmodule : tcc_checker

bind tcc_top tcc_checker #(.CNT_W(CNT_W), .RADIO_W(RADIO_W)) u_chk (.clk(clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.cap_in(cap_in), .cmp_out(cmp_out), .radio_events(radio_events), .irq(irq));

// file: tcc_pin_model.sv
`timescale 1ns/100ps

module tcc_pin_model (
	// clock
	input wire logic clk,
	// level wanted by the bench
	input wire logic [1:0] cap_lvl,
	// pins
	output logic [1:0] cap_in,
	input wire logic [1:0] cmp_out,
	// last measured widths in clocks
	output logic [1:0][7:0] hi_len,
	output logic [1:0][7:0] lo_len
);
	logic [1:0][7:0] run_ff;
	logic [1:0] last_ff;

	initial begin
		cap_in = 2'h0;
		hi_len = '0;
		lo_len = '0;
		run_ff = '0;
		last_ff = 2'h0;
	end

	// pins are driven like a synchronous source, one clock behind the request
	always @(posedge clk) begin
		cap_in <= cap_lvl;
		for (int b = 0; b < 2; b++) begin
			if (cmp_out[b] !== last_ff[b]) begin
				if (last_ff[b]) hi_len[b] <= run_ff[b];
				else lo_len[b] <= run_ff[b];
				run_ff[b] <= 8'h01;
			end else begin
				run_ff[b] <= run_ff[b] + 8'h01;
			end
			last_ff[b] <= cmp_out[b];
		end
	end
endmodule : tcc_pin_model

// file: tcc_top_tb.sv
`timescale 1ns/100ps
`include "tcc_defs.svh"

module tcc_top_tb;
	logic clk, rst_n, reg_wr, reg_rd, irq, hit;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, radio_events, d, c, stp;
	logic [1:0] cap_lvl, cap_in, cmp_out;
	logic [1:0][7:0] hi_len, lo_len;
	int failures = 0;
	int n_tests = 0;
	// action, counter mode, expected high and low widths with ch0 16, ch1 5
	logic [2:0] t_act [7] = '{3'h2, 3'h3, 3'h4, 3'h3, 3'h4, 3'h5, 3'h6};
	logic [7:0] t_mode [7] = '{8'h02, 8'h02, 8'h02, 8'h03, 8'h03, 8'h02, 8'h02};
	logic [7:0] t_hi [7] = '{8'h11, 8'h0c, 8'h05, 8'h16, 8'h0a, 8'h0b, 8'h06};
	logic [7:0] t_lo [7] = '{8'h11, 8'h05, 8'h0c, 8'h0a, 8'h16, 8'h06, 8'h0b};

	tcc_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cap_in(cap_in), .cmp_out(cmp_out),
		.radio_events(radio_events), .irq(irq));
	tcc_pin_model u_pins (.clk(clk), .cap_lvl(cap_lvl), .cap_in(cap_in), .cmp_out(cmp_out),
		.hi_len(hi_len), .lo_len(lo_len));

	// ****
	// access tasks
	// ****
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rdc
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_sim();
	end

	// ****
	// tests
	// ****
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		radio_events = 8'h00;
		cap_lvl = 2'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 'hda; a < 'he0; a++) rdc(a[7:0], `TCC_VAL_RST);
		rdc(`TCC_ADDR_CTL1, `TCC_CTL_RST);
		rdc(`TCC_ADDR_CTL2, `TCC_CTL_RST);
		wr(8'h10, 8'hff);
		rdc(8'h10, 8'h00);
		$display("test reset done");

		wr(`TCC_ADDR_CH0_LO, 8'h10);
		wr(`TCC_ADDR_CH1_LO, 8'h05);
		wr(`TCC_ADDR_CH2_LO, 8'h09);
		wr(`TCC_ADDR_CTL2, 8'h6c);
		wr(`TCC_ADDR_CTL1, 8'h44);
		wr(`TCC_ADDR_CNT_MODE, 8'h02);
		cyc(40);
		chk({7'h00, cmp_out[0]}, 8'h01);
		wr(`TCC_ADDR_CTL1, 8'h4c);
		cyc(40);
		chk({7'h00, cmp_out[0]}, 8'h00);
		for (int i = 0; i < 7; i++) begin
			wr(`TCC_ADDR_CTL1, {2'b01, t_act[i], 3'b100});
			wr(`TCC_ADDR_CNT_MODE, t_mode[i]);
			cyc(100);
			chk(hi_len[0], t_hi[i]);
			chk(lo_len[0], t_lo[i]);
		end
		chk(hi_len[1], 8'h07);
		chk(lo_len[1], 8'h0a);
		rdc(`TCC_ADDR_IRQ_STAT, 8'h07);
		$display("test compare done");

		// mid-scale word so the output keeps switching
		wr(`TCC_ADDR_CH1_HI, 8'h80);
		wr(`TCC_ADDR_CH1_LO, 8'h00);
		for (int i = 0; i < 8; i++) begin
			stp = i[2] ? 8'h04 : 8'h08;
			wr(`TCC_ADDR_CTL1, {5'h0f, i[2], i[1:0]});
			cyc(200);
			chk(hi_len[0] & (stp - 8'h01), 8'h00);
			chk(lo_len[0] & (stp - 8'h01), 8'h00);
		end
		wr(`TCC_ADDR_CTL1, 8'h40);
		wr(`TCC_ADDR_CTL2, 8'h40);
		$display("test delta-sigma done");

		// zero limit parks the counter, so the free run starts from zero
		wr(`TCC_ADDR_CH0_LO, 8'h00);
		wr(`TCC_ADDR_CNT_MODE, 8'h01);
		cyc(50);
		wr(`TCC_ADDR_CNT_MODE, 8'h00);
		wr(`TCC_ADDR_IRQ_MASK, 8'h01);
		rdc(`TCC_ADDR_CNT_HI, 8'h00);
		rdc(`TCC_ADDR_CNT_LO, 8'h34);
		c = reg_rdata;
		for (int k = 0; k < 8; k++) begin
			wr(`TCC_ADDR_CTL1, 8'h40);
			@(posedge clk) cap_lvl <= {1'b0, k[0]};
			cyc(3);
			wr(`TCC_ADDR_CTL1, {6'h10, k[2:1]});
			wr(`TCC_ADDR_CH1_LO, ~c);
			wr(`TCC_ADDR_IRQ_STAT, 8'h07);
			@(posedge clk) cap_lvl <= {1'b0, ~k[0]};
			cyc(6);
			hit = k[2:1] == 2'h3 || (k[2:1] == 2'h1 && !k[0]) || (k[2:1] == 2'h2 && k[0]);
			chk({7'h00, irq}, {7'h00, hit});
			rdc(`TCC_ADDR_IRQ_STAT, {7'h00, hit});
			rdc(`TCC_ADDR_CH1_LO, hit ? c : ~c);
		end
		$display("test capture edges done");

		wr(`TCC_ADDR_RADIO_MASK, 8'h04);
		wr(`TCC_ADDR_CTL1, 8'hc1);
		wr(`TCC_ADDR_CH1_LO, ~c);
		wr(`TCC_ADDR_IRQ_STAT, 8'h07);
		@(posedge clk) radio_events <= 8'h02;
		cyc(6);
		rdc(`TCC_ADDR_CH1_LO, ~c);
		@(posedge clk) radio_events <= 8'h06;
		cyc(6);
		rdc(`TCC_ADDR_CH1_LO, c);
		chk({7'h00, irq}, 8'h01);
		wr(`TCC_ADDR_IRQ_MASK, 8'h00);
		cyc(1);
		chk({7'h00, irq}, 8'h00);
		wr(`TCC_ADDR_IRQ_MASK, 8'h01);
		cyc(1);
		chk({7'h00, irq}, 8'h01);
		wr(`TCC_ADDR_IRQ_STAT, 8'h01);
		cyc(1);
		chk({7'h00, irq}, 8'h00);
		wr(`TCC_ADDR_CTL1, 8'h01);
		wr(`TCC_ADDR_CH1_LO, ~c);
		@(posedge clk) cap_lvl <= 2'h1;
		cyc(6);
		chk({7'h00, irq}, 8'h00);
		rdc(`TCC_ADDR_CH1_LO, c);
		$display("test radio and interrupt done");
		end_sim();
	end
endmodule : tcc_top_tb
